// ---- hw/pft_pkg.sv ----
/*
   pft_pkg: constants, register map, field positions, types and timing for the
   program flash table access controller.
   Assumes a 100 MHz core clock; the core reaches the registers by a small
   register index port and issues table operations on a request strobe.
*/
// What this block does
// - reads are byte wide, programs are 8-byte blocks, erases are 64-byte rows
// - no bulk erase exists; the core can only start a row erase
// - fetches stall during flash write or erase until the timer ends it
// - a fetched word that is no valid instruction is handed on as a no-op
// - table read copies the pointed program byte into the table latch
// - table write fills a holding register; flash changes only on long write
// - the key location has no storage and always reads zero
// - memory select 1 picks program flash, 0 picks data eeprom
// - config select 1 targets configuration space, overriding memory select
// - row erase bit makes next write erase the row; cleared when done
// - write start cannot be set while write enable is clear
// - clearing write enable mid operation leaves that operation running
// - a reset other than power-on during a timed write sets the error flag, keeps target bits
// - read and write start bits are set by software, cleared by hardware
// - read start is ignored while memory select is 1
// - an eeprom read takes one cycle, then read start clears
// - completion sets the done flag; only software or a reset clears it
// - pointer is 22 bits from three bytes; top bit selects config space
// - automatic pointer steps touch only the low 21 bits
// - pointer bits 2:0 pick holding register; bits 21:3 pick the block
// - erase uses pointer bits 21:6 as row, ignoring bits 5:0
// - table ops keep, post increment, post decrement or pre increment
package pft_pkg;

   // ----------------------------------------------------------------------
   // register map (index on the core register port)
   // ----------------------------------------------------------------------
   localparam int SFR_AW = 3;
   localparam logic [SFR_AW-1:0] SFR_CTRL = 3'h0;
   localparam logic [SFR_AW-1:0] SFR_KEY = 3'h1;
   localparam logic [SFR_AW-1:0] SFR_LATCH = 3'h2;
   localparam logic [SFR_AW-1:0] SFR_PTRL = 3'h3;
   localparam logic [SFR_AW-1:0] SFR_PTRH = 3'h4;
   localparam logic [SFR_AW-1:0] SFR_PTRU = 3'h5;

   // ----------------------------------------------------------------------
   // nvm_control field positions
   // ----------------------------------------------------------------------
   localparam int CB_RD = 0;
   localparam int CB_WR = 1;
   localparam int CB_WRITE_ENABLE_GATE = 2;
   localparam int CB_WRITE_ERROR_FLAG = 3;
   localparam int CB_FREE = 4;
   localparam int CB_CONFIG_SPACE_SELECT = 6;
   localparam int CB_MEMORY_SELECT = 7;

   // ----------------------------------------------------------------------
   // pointer, block and data constants
   // ----------------------------------------------------------------------
   localparam int PTR_W = 22;
   localparam int LOW_W = 21;
   localparam int PTRU_W = 6;
   localparam int HOLD_N = 8;
   localparam int HOLD_IW = 3;
   localparam int ROW_BYTES = 64;
   localparam int ROW_LSB = 6;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] NOP_WORD = 16'h0000;
   localparam logic [3:0] INVALID_OPC = 4'hF;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int PROG_TIME_MS = 2;
   localparam int NS_PER_MS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_CYCLES = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {PM_KEEP, PM_POST_INC, PM_POST_DEC, PM_PRE_INC} pft_ptr_mode_t;
   typedef enum logic [1:0] {KS_NONE, KS_FIRST, KS_ARMED} pft_key_t;
   typedef enum {ST_IDLE, ST_LONG, ST_EEWR} pft_state_t;

endpackage

// ---- hw/pft_flash_if.sv ----
/*
   pft_flash_if: signals between the controller and the flash array.
   Assumes one clock; strobes are single-cycle and combinational reads.
*/
`timescale 1ns/1ps

interface pft_flash_if
#(
   parameter int AW = 13
);
   logic [AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic [AW-1:0] fetch_addr;
   logic [15:0] fetch_word;
   logic prog_stb;
   logic erase_stb;
   logic [AW-1:0] op_addr;
   logic [pft_pkg::HOLD_N*8-1:0] prog_data;

   modport ctl (output rd_addr, fetch_addr, prog_stb, erase_stb, op_addr, prog_data,
      input rd_data, fetch_word);
   modport mem (input rd_addr, fetch_addr, prog_stb, erase_stb, op_addr, prog_data,
      output rd_data, fetch_word);
endinterface

// ---- hw/pft_flash_array.sv ----
/*
   pft_flash_array: byte-organised program flash model with a byte read port,
   a word fetch port, 8-byte block programming and 64-byte row erase.
   Assumes AW above 6; contents are not reset, software erases before use.
*/
`timescale 1ns/1ps

module pft_flash_array
#(
   parameter int AW = 13
)
(
   input wire logic mclk,
   pft_flash_if.mem fl
);
   import pft_pkg::*;

   logic [7:0] mem_q [0:(1<<AW)-1];

   // ---------------------------------------------------------------------
   // read ports
   // ---------------------------------------------------------------------
   // byte read for the table latch, little-endian word for fetch
   assign fl.rd_data = mem_q[fl.rd_addr];
   assign fl.fetch_word = {mem_q[{fl.fetch_addr[AW-1:1], 1'b1}],
      mem_q[{fl.fetch_addr[AW-1:1], 1'b0}]};

   // ---------------------------------------------------------------------
   // commit
   // ---------------------------------------------------------------------
   // row erase ignores the low six address bits, block write the low three
   always_ff @(posedge mclk)
   begin
      if (fl.erase_stb)
      begin
         for (int i = 0; i < ROW_BYTES; i++)
            mem_q[{fl.op_addr[AW-1:ROW_LSB], i[ROW_LSB-1:0]}] <= ERASED_BYTE;
      end
      else if (fl.prog_stb)
      begin
         for (int i = 0; i < HOLD_N; i++)
            mem_q[{fl.op_addr[AW-1:HOLD_IW], i[HOLD_IW-1:0]}] <= fl.prog_data[i*8 +: 8];
      end
   end
endmodule

// ---- hw/pft_prog_timer.sv ----
/*
   pft_prog_timer: internal programming timer; a start pulse runs it for
   CYCLES clocks and it then gives a one-cycle done pulse.
   Assumes start is not repeated while running.
*/
`timescale 1ns/1ps

module pft_prog_timer
#(
   parameter int CYCLES = pft_pkg::PROG_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

   logic [CW-1:0] count_ff;
   logic run_ff;
   logic done_ff;

   // down counter, done fires one edge after it reaches zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         count_ff <= '0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= run_ff && (count_ff == '0);
         if (start)
         begin
            count_ff <= LOAD;
            run_ff <= 1'b1;
         end
         else if (run_ff && count_ff == '0)
            run_ff <= 1'b0;
         else if (run_ff)
            count_ff <= count_ff - 1'b1;
      end
   end

   assign done = done_ff;
endmodule

// ---- hw/pft_top.sv ----
/*
   pft_top: self-programming controller for on-chip program flash. Handles
   table reads and writes through the table latch and table pointer, fills
   the holding registers, runs timed block writes and row erases, and steers
   eeprom and configuration-space operations.
   Assumes the core issues one table operation at a time, stops issuing
   fetches while fetch_stall is high, and that an external data eeprom and
   configuration store answer on the ee_ and cfg_ ports in the same clock.
*/
`timescale 1ns/1ps

module pft_top
#(
   parameter int AW = 13,
   parameter int PROG_CYCLES_P = pft_pkg::PROG_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic [pft_pkg::SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic tbl_req,
   input wire logic tbl_write,
   input wire pft_pkg::pft_ptr_mode_t tbl_mode,
   output logic tbl_done,
   input wire logic fetch_req,
   input wire logic [pft_pkg::LOW_W-1:0] fetch_addr,
   output logic [15:0] fetch_word,
   output logic fetch_valid,
   output logic fetch_stall,
   output logic [pft_pkg::PTR_W-1:0] table_pointer,
   input wire logic [7:0] cfg_rdata,
   output logic cfg_wr_stb,
   output logic [7:0] cfg_wdata,
   output logic ee_rd_stb,
   output logic ee_wr_stb,
   input wire logic ee_wr_done,
   input wire logic irq_flag_clr,
   output logic write_done_irq_flag
);
   import pft_pkg::*;

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   logic memory_select_ff;
   logic config_space_select_ff;
   logic write_error_flag_ff;
   logic op_live_ff;
   logic row_erase_ff;
   logic write_enable_gate_ff;
   logic wr_ff;
   logic rd_ff;
   pft_key_t key_ff;
   pft_state_t state_ff;
   pft_state_t nxt_state;
   logic op_erase_ff;
   logic op_cfg_ff;
   logic [PTR_W-1:0] op_addr_ff;
   logic [PTR_W-1:0] ptr_ff;
   logic [PTR_W-1:0] nxt_ptr;
   logic [7:0] latch_ff;
   logic [7:0] nxt_latch;
   logic [7:0] hold_ff [HOLD_N];
   logic pend_ff;
   logic pend_write_ff;
   pft_ptr_mode_t pend_mode_ff;
   logic [7:0] sfr_rdata_ff;
   logic tbl_done_ff;
   logic [15:0] fetch_word_ff;
   logic fetch_valid_ff;
   logic fetch_stall_ff;
   logic cfg_wr_stb_ff;
   logic [7:0] cfg_wdata_ff;
   logic ee_rd_stb_ff;
   logic ee_wr_stb_ff;
   logic irq_flag_ff;

   wire logic rst_any = rst | por_rst;

   pft_flash_if #(.AW(AW)) fl ();

   // ---------------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------------
   // one pointer step; the select bit above the low field never moves
   function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
      input logic down);
      logic [LOW_W-1:0] low;
      low = down ? p[LOW_W-1:0] - 1'b1 : p[LOW_W-1:0] + 1'b1;
      return {p[PTR_W-1], low};
   endfunction

   // words with the reserved opcode group do not decode
   function automatic logic instr_ok(input logic [15:0] w);
      return w[15:12] != INVALID_OPC;
   endfunction

   // ---------------------------------------------------------------------
   // register port decode
   // ---------------------------------------------------------------------
   wire logic ctl_wr = sfr_wr && (sfr_addr == SFR_CTRL);
   wire logic key_wr = sfr_wr && (sfr_addr == SFR_KEY);
   wire logic latch_wr = sfr_wr && (sfr_addr == SFR_LATCH);
   wire logic ptrl_wr = sfr_wr && (sfr_addr == SFR_PTRL);
   wire logic ptrh_wr = sfr_wr && (sfr_addr == SFR_PTRH);
   wire logic ptru_wr = sfr_wr && (sfr_addr == SFR_PTRU);
   wire logic idle = (state_ff == ST_IDLE);

   // target of an operation comes from the select bits as they are written
   wire logic new_config_space_select = sfr_wdata[CB_CONFIG_SPACE_SELECT];
   wire logic new_pgd = sfr_wdata[CB_MEMORY_SELECT];
   wire logic tgt_ee = !new_config_space_select && !new_pgd;

   // write start needs the enable and the full unlock sequence
   wire logic wr_set = ctl_wr && sfr_wdata[CB_WR] && write_enable_gate_ff
      && (key_ff == KS_ARMED) && !wr_ff && idle;
   wire logic long_start = wr_set && !tgt_ee;
   // eeprom read start is refused while program flash is selected
   wire logic rd_set = ctl_wr && sfr_wdata[CB_RD] && !new_pgd && !new_config_space_select
      && !rd_ff && idle;

   wire logic long_done;
   wire logic long_end = long_done && (state_ff == ST_LONG);
   wire logic ee_end = ee_wr_done && (state_ff == ST_EEWR);
   wire logic op_end = long_end || ee_end;
   wire logic life_lost = op_live_ff && idle && !wr_ff;

   // table operation handshake
   wire logic tbl_take = tbl_req && !pend_ff && (state_ff != ST_LONG);
   wire logic pend_rd = pend_ff && !pend_write_ff;
   wire logic pend_wt = pend_ff && pend_write_ff;
   wire logic post_step = pend_ff && (pend_mode_ff == PM_POST_INC
      || pend_mode_ff == PM_POST_DEC);

   // byte under the pointer: configuration space when the top bit is set
   wire logic [7:0] rd_byte = ptr_ff[PTR_W-1] ? cfg_rdata : fl.rd_data;

   wire logic [7:0] ctl_view = {memory_select_ff, config_space_select_ff, 1'b0,
      row_erase_ff, write_error_flag_ff, write_enable_gate_ff, wr_ff, rd_ff};
   wire logic [7:0] sfr_view =
      (sfr_addr == SFR_CTRL) ? ctl_view :
      (sfr_addr == SFR_KEY) ? ZERO_BYTE :
      (sfr_addr == SFR_LATCH) ? latch_ff :
      (sfr_addr == SFR_PTRL) ? ptr_ff[7:0] :
      (sfr_addr == SFR_PTRH) ? ptr_ff[15:8] :
      (sfr_addr == SFR_PTRU) ? {2'b00, ptr_ff[PTR_W-1:16]} : ZERO_BYTE;

   // ---------------------------------------------------------------------
   // flash array hookup
   // ---------------------------------------------------------------------
   assign fl.rd_addr = ptr_ff[AW-1:0];
   assign fl.fetch_addr = fetch_addr[AW-1:0];
   assign fl.op_addr = op_addr_ff[AW-1:0];
   assign fl.erase_stb = long_end && op_erase_ff;
   assign fl.prog_stb = long_end && !op_erase_ff && !op_cfg_ff;

   // holding registers form the block written by the long write
   genvar g;
   generate
      for (g = 0; g < HOLD_N; g++)
      begin : g_hold
         assign fl.prog_data[g*8 +: 8] = hold_ff[g];
      end
   endgenerate

   pft_flash_array #(.AW(AW)) u_array
   (
      .mclk(mclk),
      .fl(fl)
   );

   // the internal timer ends every flash and config write
   pft_prog_timer #(.CYCLES(PROG_CYCLES_P)) u_timer
   (
      .mclk(mclk),
      .rst(rst_any),
      .start(long_start),
      .done(long_done)
   );

   // ---------------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------------
   // pointer: register writes, then pre step on take, post step on access
   always_comb
   begin
      nxt_ptr = ptr_ff;
      if (ptrl_wr)
         nxt_ptr[7:0] = sfr_wdata;
      if (ptrh_wr)
         nxt_ptr[15:8] = sfr_wdata;
      if (ptru_wr)
         nxt_ptr[PTR_W-1:16] = sfr_wdata[PTRU_W-1:0];
      if (tbl_take && tbl_mode == PM_PRE_INC)
         nxt_ptr = ptr_step(ptr_ff, 1'b0);
      if (post_step)
         nxt_ptr = ptr_step(ptr_ff, pend_mode_ff == PM_POST_DEC);
   end

   // latch: register write or table read result
   always_comb
   begin
      nxt_latch = latch_ff;
      if (latch_wr)
         nxt_latch = sfr_wdata;
      if (pend_rd)
         nxt_latch = rd_byte;
   end

   // sequencer state
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (long_start)
               nxt_state = ST_LONG;
            else if (wr_set)
               nxt_state = ST_EEWR;
         end
         ST_LONG:
         begin
            if (long_done)
               nxt_state = ST_IDLE;
         end
         ST_EEWR:
         begin
            if (ee_wr_done)
               nxt_state = ST_IDLE;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------------
   // power-on domain: target bits and error flag survive other resets
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or posedge por_rst)
   begin
      if (por_rst)
      begin
         memory_select_ff <= 1'b0;
         config_space_select_ff <= 1'b0;
         write_error_flag_ff <= 1'b0;
         op_live_ff <= 1'b0;
      end
      else
      begin
         if (ctl_wr)
         begin
            memory_select_ff <= new_pgd;
            config_space_select_ff <= new_config_space_select;
         end
         // a live operation seen idle again was cut by a reset
         write_error_flag_ff <= life_lost
            || (ctl_wr ? sfr_wdata[CB_WRITE_ERROR_FLAG] : write_error_flag_ff);
         op_live_ff <= wr_set || (op_live_ff && !op_end && !life_lost);
      end
   end

   // ---------------------------------------------------------------------
   // control bits and sequencer
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst_any)
   begin
      if (rst_any)
      begin
         row_erase_ff <= 1'b0;
         write_enable_gate_ff <= 1'b0;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         key_ff <= KS_NONE;
         state_ff <= ST_IDLE;
         op_erase_ff <= 1'b0;
         op_cfg_ff <= 1'b0;
         op_addr_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         // enable may drop at any time without stopping a running write
         if (ctl_wr)
            write_enable_gate_ff <= sfr_wdata[CB_WRITE_ENABLE_GATE];
         // row erase bit is cleared by the end of the erase
         if (long_end && op_erase_ff)
            row_erase_ff <= 1'b0;
         else if (ctl_wr)
            row_erase_ff <= sfr_wdata[CB_FREE];
         // start bits: set by software only, cleared by hardware only
         wr_ff <= wr_set || (wr_ff && !op_end);
         rd_ff <= rd_set;
         // unlock sequence; any write-start attempt consumes it
         if (ctl_wr && sfr_wdata[CB_WR])
            key_ff <= KS_NONE;
         else if (key_wr)
            key_ff <= (sfr_wdata == KEY_FIRST) ? KS_FIRST
               : (sfr_wdata == KEY_SECOND && key_ff == KS_FIRST) ? KS_ARMED : KS_NONE;
         // only a row erase can be started; no bulk erase path exists
         if (long_start)
         begin
            op_erase_ff <= sfr_wdata[CB_FREE] && !new_config_space_select;
            op_cfg_ff <= new_config_space_select;
            op_addr_ff <= ptr_ff;
         end
      end
   end

   // ---------------------------------------------------------------------
   // table pointer, latch and table operation pipeline
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst_any)
   begin
      if (rst_any)
      begin
         ptr_ff <= '0;
         latch_ff <= ZERO_BYTE;
         pend_ff <= 1'b0;
         pend_write_ff <= 1'b0;
         pend_mode_ff <= PM_KEEP;
      end
      else
      begin
         ptr_ff <= nxt_ptr;
         latch_ff <= nxt_latch;
         pend_ff <= tbl_take;
         if (tbl_take)
         begin
            pend_write_ff <= tbl_write;
            pend_mode_ff <= tbl_mode;
         end
      end
   end

   // holding registers: low pointer bits pick the byte, blank after a flash block program
   always_ff @(posedge mclk or posedge rst_any)
   begin
      if (rst_any)
      begin
         for (int i = 0; i < HOLD_N; i++)
            hold_ff[i] <= ERASED_BYTE;
      end
      else if (fl.prog_stb)
      begin
         for (int i = 0; i < HOLD_N; i++)
            hold_ff[i] <= ERASED_BYTE;
      end
      else if (pend_wt)
         hold_ff[ptr_ff[HOLD_IW-1:0]] <= latch_ff;
   end

   // ---------------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst_any)
   begin
      if (rst_any)
      begin
         sfr_rdata_ff <= ZERO_BYTE;
         tbl_done_ff <= 1'b0;
         fetch_word_ff <= NOP_WORD;
         fetch_valid_ff <= 1'b0;
         fetch_stall_ff <= 1'b0;
         cfg_wr_stb_ff <= 1'b0;
         cfg_wdata_ff <= ZERO_BYTE;
         ee_rd_stb_ff <= 1'b0;
         ee_wr_stb_ff <= 1'b0;
         irq_flag_ff <= 1'b0;
      end
      else
      begin
         sfr_rdata_ff <= sfr_view;
         tbl_done_ff <= pend_ff;
         fetch_stall_ff <= (nxt_state == ST_LONG);
         fetch_valid_ff <= fetch_req && (state_ff != ST_LONG) && !long_start;
         fetch_word_ff <= instr_ok(fl.fetch_word) ? fl.fetch_word : NOP_WORD;
         cfg_wr_stb_ff <= long_end && op_cfg_ff;
         if (long_end && op_cfg_ff)
            cfg_wdata_ff <= hold_ff[op_addr_ff[HOLD_IW-1:0]];
         ee_rd_stb_ff <= rd_set;
         ee_wr_stb_ff <= wr_set && tgt_ee;
         // completion sets the flag and wins over a clear in the same cycle
         irq_flag_ff <= op_end || (irq_flag_ff && !irq_flag_clr);
      end
   end

   assign sfr_rdata = sfr_rdata_ff;
   assign tbl_done = tbl_done_ff;
   assign fetch_word = fetch_word_ff;
   assign fetch_valid = fetch_valid_ff;
   assign fetch_stall = fetch_stall_ff;
   assign table_pointer = ptr_ff;
   assign cfg_wr_stb = cfg_wr_stb_ff;
   assign cfg_wdata = cfg_wdata_ff;
   assign ee_rd_stb = ee_rd_stb_ff;
   assign ee_wr_stb = ee_wr_stb_ff;
   assign write_done_irq_flag = irq_flag_ff;
endmodule

// ---- tb/pft_top_properties.sv ----
/* pft_chk: port assertions for pft_top, bound below.
   Assumes the pft_pkg register map and one clock domain. */
`timescale 1ns/1ps
module pft_chk
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic [pft_pkg::SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_stall,
   input wire logic [pft_pkg::PTR_W-1:0] table_pointer,
   input wire logic cfg_wr_stb,
   input wire logic ee_rd_stb,
   input wire logic ee_wr_stb,
   input wire logic irq_flag_clr,
   input wire logic write_done_irq_flag
);
   import pft_pkg::*;
   // core clock only, quiet in either reset
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || por_rst);
   AST_KEY_ZERO: assert property (sfr_addr == SFR_KEY |=> sfr_rdata == 8'h00)
      else $error("key read nonzero");
   AST_NO_FETCH: assert property (fetch_stall |=> !fetch_valid)
      else $error("fetch during long write");
   AST_NOP: assert property (fetch_valid |-> fetch_word[15:12] != INVALID_OPC)
      else $error("invalid word passed");
   AST_PTR_TOP: assert property ($changed(table_pointer[LOW_W]) |->
      $past(sfr_wr) && $past(sfr_addr) == SFR_PTRU) else $error("pointer top bit moved");
   AST_RD: assert property (ee_rd_stb |-> !$past(sfr_wdata[CB_MEMORY_SELECT]) ##1 !ee_rd_stb)
      else $error("bad read strobe");
   AST_IRQ: assert property (write_done_irq_flag && !irq_flag_clr |=> write_done_irq_flag)
      else $error("done flag dropped");
   AST_CFG: assert property (cfg_wr_stb |-> $past(fetch_stall))
      else $error("config write without long write");
   AST_EE: assert property (ee_wr_stb |-> !fetch_stall ##1 !fetch_stall)
      else $error("eeprom write stalled");
endmodule
bind pft_top pft_chk chk (.*);

// ---- tb/pft_ext_model.sv ----
/* pft_ext_model: data eeprom and one configuration byte beside pft_top.
   Assumes single-cycle write strobes. */
`timescale 1ns/1ps
module pft_ext_model
(
   input wire logic mclk,
   input wire logic ee_wr_stb,
   input wire logic cfg_wr_stb,
   input wire logic [7:0] cfg_wdata,
   output logic ee_wr_done,
   output logic [7:0] cfg_rdata
);
   initial ee_wr_done = 1'b0;
   initial cfg_rdata = 8'h5A;
   // eeprom write ends a cycle after start; config byte stored
   always @(posedge mclk)
   begin
      ee_wr_done <= ee_wr_stb;
      if (cfg_wr_stb) cfg_rdata <= cfg_wdata;
   end
endmodule

// ---- tb/tb_program_flash_table_access.sv ----
/* tb_program_flash_table_access: directed bench for pft_top.
   Assumes a short programming timer and pft_ext_model as far side. */
`timescale 1ns/1ps
module tb_program_flash_table_access;
   import pft_pkg::*;
   localparam int P = 20;
   logic mclk = 1'b0, rst = 1'b1, por_rst = 1'b1, sfr_wr = 1'b0, tbl_req = 1'b0;
   logic tbl_write = 1'b0, fetch_req = 1'b0, irq_flag_clr = 1'b0;
   logic [2:0] sfr_addr = 3'h0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [20:0] fetch_addr = 21'h0;
   pft_ptr_mode_t tbl_mode = PM_KEEP;
   logic [7:0] sfr_rdata, cfg_rdata, cfg_wdata;
   logic [15:0] fetch_word;
   logic [21:0] table_pointer;
   logic tbl_done, fetch_valid, fetch_stall, cfg_wr_stb, ee_rd_stb, ee_wr_stb, ee_wr_done;
   logic write_done_irq_flag;
   int error_cnt = 0, check_count = 0;
   always #5 mclk = ~mclk;
   pft_top #(.PROG_CYCLES_P(P)) uut (.*);
   pft_ext_model ext (.mclk, .ee_wr_stb, .cfg_wr_stb, .cfg_wdata, .ee_wr_done, .cfg_rdata);
   // compare and bus helpers
   task chk(input logic [21:0] got, input logic [21:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      sfr_addr <= a;
      @(posedge mclk);
      #1 chk(sfr_rdata, exp);
   endtask
   task tbl(input logic w, input pft_ptr_mode_t m);
      @(posedge mclk);
      tbl_req <= 1'b1;
      tbl_write <= w;
      tbl_mode <= m;
      @(posedge mclk);
      tbl_req <= 1'b0;
      @(posedge mclk);
      #1 chk(tbl_done, 1'b1);
   endtask
   task fetch(input logic [20:0] a, input logic [15:0] exp);
      @(posedge mclk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge mclk);
      fetch_req <= 1'b0;
      #1 chk(fetch_word, exp);
      chk(fetch_valid, 1'b1);
   endtask
   task ptr(input logic [21:0] p);
      wr(SFR_PTRL, p[7:0]);
      wr(SFR_PTRH, p[15:8]);
      wr(SFR_PTRU, {2'b00, p[21:16]});
   endtask
   task go(input logic [7:0] c);
      wr(SFR_CTRL, c);
      wr(SFR_KEY, KEY_FIRST);
      wr(SFR_KEY, KEY_SECOND);
      wr(SFR_CTRL, c | 8'h02);
   endtask
   task clr;
      @(posedge mclk);
      irq_flag_clr <= 1'b1;
      @(posedge mclk);
      irq_flag_clr <= 1'b0;
   endtask
   task print_verdict;
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // key reads, refused starts, eeprom read
   task t_regs;
      rd(SFR_KEY, ZERO_BYTE);
      go(8'h00);
      rd(SFR_CTRL, ZERO_BYTE);
      wr(SFR_CTRL, 8'h81);
      rd(SFR_CTRL, 8'h80);
      wr(SFR_CTRL, 8'h01);
      rd(SFR_CTRL, ZERO_BYTE);
   endtask
   // erase row, fill holding registers, program block, read back and fetch
   task t_flash;
      ptr(22'h000040);
      go(8'h94);
      #1 chk(fetch_stall, 1'b1);
      wr(SFR_CTRL, 8'h90);
      rd(SFR_CTRL, 8'h92);
      repeat (P) @(posedge mclk);
      #1 chk(fetch_stall, 1'b0);
      rd(SFR_CTRL, 8'h80);
      chk(write_done_irq_flag, 1'b1);
      clr;
      for (int i = 0; i < 8; i++)
      begin
         wr(SFR_LATCH, 8'h23 * i[7:0]);
         tbl(1'b1, PM_POST_INC);
      end
      ptr(22'h000040);
      tbl(1'b0, PM_KEEP);
      rd(SFR_LATCH, ERASED_BYTE);
      ptr(22'h000045);
      go(8'h84);
      repeat (P + 2) @(posedge mclk);
      ptr(22'h000040);
      for (int i = 0; i < 9; i++)
      begin
         tbl(1'b0, PM_POST_INC);
         rd(SFR_LATCH, i < 8 ? 8'h23 * i[7:0] : ERASED_BYTE);
      end
      fetch(21'h000040, 16'h2300);
      fetch(21'h000046, NOP_WORD);
   endtask
   // pointer wrap and config space write
   task t_cfg;
      ptr(22'h3FFFFF);
      tbl(1'b0, PM_PRE_INC);
      chk(table_pointer, 22'h200000);
      rd(SFR_LATCH, 8'h5A);
      tbl(1'b0, PM_POST_DEC);
      rd(SFR_PTRU, 8'h3F);
      wr(SFR_LATCH, 8'h3C);
      tbl(1'b1, PM_KEEP);
      go(8'hC4);
      repeat (P + 2) @(posedge mclk);
      tbl(1'b0, PM_KEEP);
      rd(SFR_LATCH, 8'h3C);
   endtask
   // eeprom write, then a reset that cuts a flash write short
   task t_ee_reset;
      clr;
      go(8'h04);
      #1 chk(fetch_stall, 1'b0);
      repeat (4) @(posedge mclk);
      rd(SFR_CTRL, 8'h04);
      chk(write_done_irq_flag, 1'b1);
      go(8'h84);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(SFR_CTRL, 8'h88);
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      por_rst <= 1'b0;
      t_regs;
      t_flash;
      t_cfg;
      t_ee_reset;
      print_verdict;
   end
   // hang guard, well past the expected run
   initial
   begin
      #50us;
      error_cnt++;
      print_verdict;
   end
endmodule
